// ---- aupcd_pkg.sv ----
// Constants for the audio port clock checking block
`default_nettype none
package aupcd_pkg;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_FRAME_RATIO_AND_RATE_MODE = 8'h28;
  localparam logic [7:0] OFS_CLOCK_CHECK_IGNORE_MASK = 8'h29;
  localparam logic [7:0] OFS_SERIAL_OUT_SOURCE_SELECT = 8'h30;
  localparam logic [7:0] OFS_BIT_CLOCK_POLARITY_CONTROL = 8'h31;
  localparam logic [7:0] OFS_SERIAL_PORT_CONTROL_ONE = 8'h33;
  localparam logic [7:0] OFS_DETECTED_RATE_MONITOR = 8'h37;
  localparam logic [7:0] OFS_DETECTED_RATIO_LOW = 8'h38;
  localparam logic [7:0] OFS_CLOCK_CHECK_STATUS = 8'h39;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_FRAME_RATIO_AND_RATE_MODE = 8'h00;
  localparam logic [7:0] RST_CLOCK_CHECK_IGNORE_MASK = 8'h00;
  localparam logic [7:0] RST_SERIAL_OUT_SOURCE_SELECT = 8'h00;
  localparam logic [7:0] RST_BIT_CLOCK_POLARITY_CONTROL = 8'h00;
  localparam logic [7:0] RST_SERIAL_PORT_CONTROL_ONE = 8'h02;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int POS_CONFIGURED_FRAME_RATIO = 4;
  localparam int POS_RATE_MODE_SELECT = 0;
  localparam int POS_IGNORE_PLL_OVERRATE = 6;
  localparam int POS_IGNORE_BITCLK_RANGE = 5;
  localparam int POS_IGNORE_RATE_ERROR = 4;
  localparam int POS_IGNORE_BITCLK_RATIO = 3;
  localparam int POS_IGNORE_MISSING_BITCLK = 2;
  localparam int POS_SERIAL_OUT_SOURCE = 0;
  localparam int POS_BITCLK_POLARITY_INVERT = 5;
  // Status bits
  localparam int POS_ST_RATE_ERR = 0;
  localparam int POS_ST_RATIO_ERR = 1;
  localparam int POS_ST_RANGE_ERR = 2;
  localparam int POS_ST_MISSING = 3;
  localparam int POS_ST_PLL_ERR = 4;
  localparam int POS_ST_CLOCK_ERR = 5;
  // ----------------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] RATIO_32 = 4'h3;
  localparam logic [3:0] RATIO_64 = 4'h5;
  localparam logic [3:0] RATIO_128 = 4'h7;
  localparam logic [3:0] RATIO_256 = 4'h9;
  localparam logic [3:0] RATIO_512 = 4'hB;
  localparam logic [3:0] RATE_AUTO = 4'h0;
  localparam logic [3:0] RATE_ERROR = 4'h0;
  localparam logic [3:0] RATE_8K = 4'h2;
  localparam logic [3:0] RATE_16K = 4'h4;
  localparam logic [3:0] RATE_32K = 4'h6;
  localparam logic [3:0] RATE_44K1 = 4'h8;
  localparam logic [3:0] RATE_48K = 4'h9;
  localparam logic [3:0] RATE_88K2 = 4'hA;
  localparam logic [3:0] RATE_96K = 4'hB;
  localparam logic [9:0] MIN_BITS_PER_FRAME = 10'h020;
  localparam logic [9:0] MAX_BITS_PER_FRAME = 10'h200;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int BITCLK_MIN_HZ = 256000;
  localparam int BITCLK_MAX_HZ = 50000000;
  localparam int MISS_TIME_US = 100;
  // Longest legal bit clock period rounds down, shortest rounds up
  localparam int BITCLK_MAX_PER_CYC = CLK_HZ / BITCLK_MIN_HZ;
  localparam int BITCLK_MIN_PER_CYC =
    (CLK_HZ + BITCLK_MAX_HZ - 1) / BITCLK_MAX_HZ;
  localparam int MISS_CYC = MISS_TIME_US * (CLK_HZ / 1000000);
endpackage : aupcd_pkg
`default_nettype wire

// ---- aupcd_top.sv ----
// Audio serial port clock checking and control registers
`default_nettype none
// Functional notes
// - Ratio field codes 32 to 512 bit clocks
// - Rate mode zero auto-detects, else must match
// - Fixed rate codes 8 kHz to 96 kHz
// - PLL overrate flagged, maskable from clock error
// - Bit clock outside 256k-50M flagged, maskable
// - Masked rate error still shows in status
// - Bits per frame outside 32..512 flagged, maskable
// - Missing bit clock flagged, maskable
// - Output source fixed at processed data, source select reads zero
// - Polarity bit picks bit clock sampling edge
// - Monitor registers 0x37 and 0x38 show detected rate and ratio; status holds the error flags
module aupcd_top #(
  parameter int P_MISS_CYCLES = aupcd_pkg::MISS_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic I_BIT_CLOCK,
  input wire logic I_FRAME_CLOCK,
  input wire logic I_SERIAL_IN,
  input wire logic I_PLL_OVERRATE,
  input wire logic I_PROCESSED_DATA,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WRITE,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  output logic O_CLOCK_ERROR,
  output logic O_SERIAL_OUT,
  output logic O_SAMPLED_DATA
);
  // ----------------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_MISSING = 2'b01,
    ST_RUN = 2'b10
  } aupcd_mon_t;

  typedef struct packed {
    logic [2:0] bclk_s;
    logic [2:0] frame_s;
    logic [2:0] sdin_s;
    logic [2:0] pll_s;
    logic bclk_f;
    logic frame_f;
    logic sdin_f;
    logic pll_f;
    logic [7:0] ratio_rate_mode;
    logic [7:0] ignore_mask;
    logic [7:0] polarity_ctrl;
    logic [7:0] sap_ctrl;
    aupcd_mon_t mon;
    logic [7:0] bclk_per;
    logic range_err;
    logic [15:0] miss_cnt;
    logic [13:0] frame_cyc;
    logic [9:0] bit_cnt;
    logic [9:0] det_ratio;
    logic [3:0] det_rate;
    logic [5:0] status;
    logic [7:0] rdata;
    logic clk_err;
    logic sdout;
    logic sampled;
  } aupcd_state_t;

  aupcd_state_t st;
  aupcd_state_t next_st;

  // Source select has no write path, so it is a fixed value
  localparam logic [7:0] RST_SRC = aupcd_pkg::RST_SERIAL_OUT_SOURCE_SELECT;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Frame period within about 3 percent of nominal
  function automatic logic aupcd_near(input logic [13:0] per,
                                      input int hz);
    int nom;
    int tol;
    nom = aupcd_pkg::CLK_HZ / hz;
    tol = nom / 32;
    return (int'(per) >= nom - tol) && (int'(per) <= nom + tol);
  endfunction : aupcd_near

  // Frame period in system cycles to rate code
  function automatic logic [3:0] aupcd_rate(input logic [13:0] per);
    logic [3:0] code;
    code = aupcd_pkg::RATE_ERROR;
    if (aupcd_near(per, 8000)) code = aupcd_pkg::RATE_8K;
    if (aupcd_near(per, 16000)) code = aupcd_pkg::RATE_16K;
    if (aupcd_near(per, 32000)) code = aupcd_pkg::RATE_32K;
    if (aupcd_near(per, 44100)) code = aupcd_pkg::RATE_44K1;
    if (aupcd_near(per, 48000)) code = aupcd_pkg::RATE_48K;
    if (aupcd_near(per, 88200)) code = aupcd_pkg::RATE_88K2;
    if (aupcd_near(per, 96000)) code = aupcd_pkg::RATE_96K;
    return code;
  endfunction : aupcd_rate

  // Configured ratio code to bits per frame, zero when not a valid code
  function automatic logic [9:0] aupcd_ratio(input logic [3:0] code);
    case (code)
      aupcd_pkg::RATIO_32: return 10'h020;
      aupcd_pkg::RATIO_64: return 10'h040;
      aupcd_pkg::RATIO_128: return 10'h080;
      aupcd_pkg::RATIO_256: return 10'h100;
      aupcd_pkg::RATIO_512: return 10'h200;
      default: return 10'h000;
    endcase
  endfunction : aupcd_ratio

  // Three stage synchroniser, value taken once stages two and three agree
  function automatic logic aupcd_filt(input logic [2:0] s,
                                      input logic old);
    return (s[1] == s[2]) ? s[2] : old;
  endfunction : aupcd_filt

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic bclk_rise;
    logic bclk_fall;
    logic act_edge;
    logic frame_rise;
    logic inv;
    logic [3:0] mode;
    logic [9:0] cfg_bits;
    logic rate_err;
    logic ratio_err;
    logic missing;
    bclk_rise = 1'b0;
    bclk_fall = 1'b0;
    act_edge = 1'b0;
    frame_rise = 1'b0;
    inv = 1'b0;
    mode = 4'h0;
    cfg_bits = 10'h000;
    rate_err = 1'b0;
    ratio_err = 1'b0;
    missing = 1'b0;
    next_st = st;

    // Pin synchronisers; stage one feeds only stage two
    next_st.bclk_s = {st.bclk_s[1:0], I_BIT_CLOCK};
    next_st.frame_s = {st.frame_s[1:0], I_FRAME_CLOCK};
    next_st.sdin_s = {st.sdin_s[1:0], I_SERIAL_IN};
    next_st.pll_s = {st.pll_s[1:0], I_PLL_OVERRATE};
    next_st.bclk_f = aupcd_filt(st.bclk_s, st.bclk_f);
    next_st.frame_f = aupcd_filt(st.frame_s, st.frame_f);
    next_st.sdin_f = aupcd_filt(st.sdin_s, st.sdin_f);
    next_st.pll_f = aupcd_filt(st.pll_s, st.pll_f);

    bclk_rise = next_st.bclk_f & ~st.bclk_f;
    bclk_fall = ~next_st.bclk_f & st.bclk_f;
    frame_rise = next_st.frame_f & ~st.frame_f;
    inv = st.polarity_ctrl[aupcd_pkg::POS_BITCLK_POLARITY_INVERT];
    // Edges launch on one bit clock edge, so sample on the other
    act_edge = inv ? bclk_fall : bclk_rise;

    // Register writes; source select is read only, stays at reset
    if (I_REG_WRITE) begin
      case (I_REG_ADDR)
        aupcd_pkg::OFS_FRAME_RATIO_AND_RATE_MODE:
          next_st.ratio_rate_mode = I_REG_WDATA;
        aupcd_pkg::OFS_CLOCK_CHECK_IGNORE_MASK:
          next_st.ignore_mask = I_REG_WDATA;
        aupcd_pkg::OFS_BIT_CLOCK_POLARITY_CONTROL:
          next_st.polarity_ctrl = I_REG_WDATA;
        aupcd_pkg::OFS_SERIAL_PORT_CONTROL_ONE:
          next_st.sap_ctrl = I_REG_WDATA;
        default: next_st.sap_ctrl = st.sap_ctrl;
      endcase
    end

    // Bit clock period and missing clock watch
    if (act_edge) begin
      next_st.bclk_per = 8'h00;
      next_st.miss_cnt = 16'h0000;
      next_st.range_err = (int'(st.bclk_per) + 1 <
                           aupcd_pkg::BITCLK_MIN_PER_CYC) ||
                          (int'(st.bclk_per) + 1 >
                           aupcd_pkg::BITCLK_MAX_PER_CYC);
    end else begin
      if (st.bclk_per != 8'hFF) next_st.bclk_per = st.bclk_per + 8'h01;
      if (int'(st.miss_cnt) < P_MISS_CYCLES)
        next_st.miss_cnt = st.miss_cnt + 16'h0001;
      // Too slow a clock is a range error before the next edge arrives
      if (int'(st.bclk_per) >= aupcd_pkg::BITCLK_MAX_PER_CYC)
        next_st.range_err = 1'b1;
    end

    // Monitor state: missing until edges seen again
    case (st.mon)
      ST_MISSING: if (act_edge) next_st.mon = ST_RUN;
      ST_RUN: begin
        if (int'(st.miss_cnt) >= P_MISS_CYCLES)
          next_st.mon = ST_MISSING;
      end
      default: next_st.mon = ST_MISSING;
    endcase
    missing = (st.mon != ST_RUN);

    // Frame measurement, latched at each frame start
    if (st.frame_cyc != 14'h3FFF) next_st.frame_cyc = st.frame_cyc + 14'h0001;
    if (act_edge && st.bit_cnt != 10'h3FF)
      next_st.bit_cnt = st.bit_cnt + 10'h001;
    if (frame_rise) begin
      next_st.frame_cyc = 14'h0001;
      next_st.bit_cnt = {9'h000, act_edge};
      next_st.det_ratio = st.bit_cnt;
      next_st.det_rate = aupcd_rate(st.frame_cyc);
    end
    // A lost clock leaves no valid measurement
    if (missing) begin
      next_st.det_rate = aupcd_pkg::RATE_ERROR;
      next_st.det_ratio = 10'h000;
    end

    // Rate check: auto takes the detected rate, a fixed mode must match
    mode = st.ratio_rate_mode[aupcd_pkg::POS_RATE_MODE_SELECT +: 4];
    rate_err = (st.det_rate == aupcd_pkg::RATE_ERROR) ||
               ((mode != aupcd_pkg::RATE_AUTO) &&
                (mode != st.det_rate));
    cfg_bits = aupcd_ratio(
      st.ratio_rate_mode[aupcd_pkg::POS_CONFIGURED_FRAME_RATIO +: 4]);
    ratio_err = (st.det_ratio < aupcd_pkg::MIN_BITS_PER_FRAME) ||
                (st.det_ratio > aupcd_pkg::MAX_BITS_PER_FRAME) ||
                ((cfg_bits != 10'h000) &&
                 (cfg_bits != st.det_ratio));

    // Status always shows raw errors, masks only gate the clock error
    next_st.status[aupcd_pkg::POS_ST_RATE_ERR] = rate_err;
    next_st.status[aupcd_pkg::POS_ST_RATIO_ERR] = ratio_err;
    next_st.status[aupcd_pkg::POS_ST_RANGE_ERR] = st.range_err;
    next_st.status[aupcd_pkg::POS_ST_MISSING] = missing;
    next_st.status[aupcd_pkg::POS_ST_PLL_ERR] = st.pll_f;
    next_st.clk_err =
      (st.pll_f & ~st.ignore_mask[aupcd_pkg::POS_IGNORE_PLL_OVERRATE]) |
      (st.range_err &
       ~st.ignore_mask[aupcd_pkg::POS_IGNORE_BITCLK_RANGE]) |
      (rate_err & ~st.ignore_mask[aupcd_pkg::POS_IGNORE_RATE_ERROR]) |
      (ratio_err & ~st.ignore_mask[aupcd_pkg::POS_IGNORE_BITCLK_RATIO]) |
      (missing &
       ~st.ignore_mask[aupcd_pkg::POS_IGNORE_MISSING_BITCLK]);
    next_st.status[aupcd_pkg::POS_ST_CLOCK_ERR] = st.clk_err;

    // Serial data capture and output source
    if (act_edge) next_st.sampled = st.sdin_f;
    next_st.sdout =
      RST_SRC[aupcd_pkg::POS_SERIAL_OUT_SOURCE] ?
      st.sampled : I_PROCESSED_DATA;

    // Read data, registered; unmapped offsets read zero
    case (I_REG_ADDR)
      aupcd_pkg::OFS_FRAME_RATIO_AND_RATE_MODE:
        next_st.rdata = st.ratio_rate_mode;
      aupcd_pkg::OFS_CLOCK_CHECK_IGNORE_MASK:
        next_st.rdata = st.ignore_mask;
      aupcd_pkg::OFS_SERIAL_OUT_SOURCE_SELECT: next_st.rdata = RST_SRC;
      aupcd_pkg::OFS_BIT_CLOCK_POLARITY_CONTROL:
        next_st.rdata = st.polarity_ctrl;
      aupcd_pkg::OFS_SERIAL_PORT_CONTROL_ONE: next_st.rdata = st.sap_ctrl;
      aupcd_pkg::OFS_DETECTED_RATE_MONITOR:
        next_st.rdata = {2'b00, st.det_ratio[9:8], st.det_rate};
      aupcd_pkg::OFS_DETECTED_RATIO_LOW:
        next_st.rdata = st.det_ratio[7:0];
      aupcd_pkg::OFS_CLOCK_CHECK_STATUS:
        next_st.rdata = {2'b00, st.status};
      default: next_st.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      st <= '0;
      st.ratio_rate_mode <= aupcd_pkg::RST_FRAME_RATIO_AND_RATE_MODE;
      st.ignore_mask <= aupcd_pkg::RST_CLOCK_CHECK_IGNORE_MASK;
      st.polarity_ctrl <= aupcd_pkg::RST_BIT_CLOCK_POLARITY_CONTROL;
      st.sap_ctrl <= aupcd_pkg::RST_SERIAL_PORT_CONTROL_ONE;
      st.mon <= ST_MISSING;
      // Synchronisers keep tracking the pins, so no false edge after reset
      st.bclk_s <= next_st.bclk_s;
      st.frame_s <= next_st.frame_s;
      st.sdin_s <= next_st.sdin_s;
      st.pll_s <= next_st.pll_s;
      st.bclk_f <= next_st.bclk_f;
      st.frame_f <= next_st.frame_f;
      st.sdin_f <= next_st.sdin_f;
      st.pll_f <= next_st.pll_f;
    end else begin
      st <= next_st;
    end
  end

  assign O_REG_RDATA = st.rdata;
  assign O_CLOCK_ERROR = st.clk_err;
  assign O_SERIAL_OUT = st.sdout;
  assign O_SAMPLED_DATA = st.sampled;
endmodule : aupcd_top
`default_nettype wire

// ---- aupcd_chk_sva.sv ----
// Port-level assertion checker for the audio port clock checking block
`default_nettype none
module aupcd_chk #(
  parameter int P_MISS_CYCLES = aupcd_pkg::MISS_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic I_BIT_CLOCK,
  input wire logic I_FRAME_CLOCK,
  input wire logic I_SERIAL_IN,
  input wire logic I_PLL_OVERRATE,
  input wire logic I_PROCESSED_DATA,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WRITE,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic O_CLOCK_ERROR,
  input wire logic O_SERIAL_OUT,
  input wire logic O_SAMPLED_DATA
);
  // ----------------------------------------------------------------
  // Shadow of the ignore mask and bit clock quiet time
  // ----------------------------------------------------------------
  localparam int LIM = P_MISS_CYCLES + 20;
  logic [7:0] mask;
  logic [15:0] idle;
  logic [9:0] act_idle;
  logic inv;
  logic bq;
  function automatic logic mapped(input logic [7:0] a);
    return a inside {8'h28, 8'h29, 8'h30, 8'h31, 8'h33, 8'h37, 8'h38, 8'h39};
  endfunction : mapped
  // Idle count saturates so a long stop cannot wrap back to busy
  always_ff @(posedge I_MCLK) begin
    bq <= I_BIT_CLOCK;
    if (I_SRST) begin
      mask <= 8'h00;
      inv <= 1'b0;
      idle <= 16'h0000;
      act_idle <= 10'h000;
    end else begin
      if (I_REG_WRITE && I_REG_ADDR == 8'h29) begin
        mask <= I_REG_WDATA;
      end
      if (I_REG_WRITE && I_REG_ADDR == 8'h31) begin
        inv <= I_REG_WDATA[5];
      end
      idle <= (I_BIT_CLOCK != bq) ? 16'h0000 : idle + {15'h0000, ~&idle};
      // Counts only from pin edges in the sampling direction
      act_idle <= (I_BIT_CLOCK != bq && I_BIT_CLOCK != inv) ? 10'h000 :
        act_idle + {9'h000, ~&act_idle};
    end
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_unmapped_zero: assert property (!$past(I_SRST) &&
    !mapped($past(I_REG_ADDR)) |-> O_REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_source_fixed: assert property (!$past(I_SRST) &&
    $past(I_REG_ADDR) == 8'h30 |-> O_REG_RDATA == 8'h00)
    else $error("source select not zero");
  a_serout_follow: assert property (!$past(I_SRST) |->
    O_SERIAL_OUT == $past(I_PROCESSED_DATA))
    else $error("serial out not processed data");
  a_reg_readback: assert property (I_REG_WRITE &&
    I_REG_ADDR inside {8'h28, 8'h29, 8'h33} ##1
    !I_REG_WRITE && $stable(I_REG_ADDR) |=>
    O_REG_RDATA == $past(I_REG_WDATA, 2))
    else $error("written value not read back");
  a_pll_error: assert property ((I_PLL_OVERRATE && !mask[6])[*8]
    |-> O_CLOCK_ERROR) else $error("PLL overrate not flagged");
  a_all_masked: assert property ((mask[6:2] == 5'h1F)[*8]
    |-> !O_CLOCK_ERROR) else $error("clock error while all ignored");
  a_status_pll: assert property ((I_REG_ADDR == 8'h39 &&
    I_PLL_OVERRATE)[*8] |-> O_REG_RDATA[4])
    else $error("PLL overrate missing from status");
  a_missing_error: assert property ((idle > LIM && !mask[2])[*4]
    |-> O_CLOCK_ERROR) else $error("missing bit clock not flagged");
  a_sample_edge: assert property ($changed(O_SAMPLED_DATA)
    |-> act_idle < 10'h005) else $error("sample not on active edge");
endmodule : aupcd_chk
bind aupcd_top aupcd_chk #(.P_MISS_CYCLES(P_MISS_CYCLES)) i_chk (
  .I_MCLK, .I_SRST, .I_BIT_CLOCK, .I_FRAME_CLOCK, .I_SERIAL_IN,
  .I_PLL_OVERRATE, .I_PROCESSED_DATA, .I_REG_ADDR, .I_REG_WRITE,
  .I_REG_WDATA, .O_REG_RDATA, .O_CLOCK_ERROR, .O_SERIAL_OUT,
  .O_SAMPLED_DATA);
`default_nettype wire

// ---- aupcd_host_model.sv ----
// Behavioural audio source driving bit clock, frame clock and data
`default_nettype none
module aupcd_host_model (
  input wire logic i_run,
  input wire logic i_invert,
  input wire logic [15:0] i_half,
  input wire logic [9:0] i_bits,
  output logic o_bit_clock,
  output logic o_frame_clock,
  output logic o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Frame generator
  // ----------------------------------------------------------------
  initial begin
    o_bit_clock = 1'b0;
    o_frame_clock = 1'b0;
    o_data = 1'b0;
    #7; // Phase unrelated to the system clock
    forever begin
      if (!i_run) begin
        // Clocks stand still; data line floats so it keeps toggling
        o_bit_clock = i_invert;
        o_data = ~o_data;
        #(i_half);
      end else begin
        for (int b = 0; b < i_bits; b++) begin
          // Frame and data move on the aligning edge only
          o_bit_clock = i_invert;
          o_frame_clock = (b >= i_bits / 2);
          o_data = b[0] ^ b[3];
          #(i_half);
          o_bit_clock = ~i_invert;
          #(i_half);
        end
      end
    end
  end
endmodule : aupcd_host_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the audio port clock checking block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic pll = 1'b0;
  logic pdat = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic run = 1'b0;
  logic inv = 1'b0;
  logic s0;
  logic [15:0] half = 16'h0050;
  logic bclk, fclk, sdin, clk_err, sout, samp;
  logic [7:0] rdata;
  logic [7:0] ra [6] = '{8'h28, 8'h29, 8'h30, 8'h31, 8'h33, 8'h50};
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  logic [3:0] rc [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB};
  logic [3:0] qc [5] = '{4'h3, 4'h7, 4'h9, 4'hB, 4'h5};
  int num_errors = 0;
  int tests_run = 0;
  // ----------------------------------------------------------------
  // Clock, source model and design
  // ----------------------------------------------------------------
  always #10 clk = ~clk;
  aupcd_host_model i_host (.i_run(run), .i_invert(inv), .i_half(half),
    .i_bits(10'h040), .o_bit_clock(bclk), .o_frame_clock(fclk),
    .o_data(sdin));
  aupcd_top #(.P_MISS_CYCLES(300)) i_dut (.I_MCLK(clk), .I_SRST(srst),
    .I_BIT_CLOCK(bclk), .I_FRAME_CLOCK(fclk), .I_SERIAL_IN(sdin),
    .I_PLL_OVERRATE(pll), .I_PROCESSED_DATA(pdat), .I_REG_ADDR(addr),
    .I_REG_WRITE(wr_en), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
    .O_CLOCK_ERROR(clk_err), .O_SERIAL_OUT(sout), .O_SAMPLED_DATA(samp));
  // ----------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task automatic fail(input string m);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  // Polls the masked read; a bound above one is a wait that may time out
  task automatic chk(input logic [7:0] a, e, m, input int n);
    int i;
    tests_run++;
    @(posedge clk);
    addr <= a;
    for (i = 0; i < n; i++) begin
      repeat (2) @(posedge clk);
      #1;
      if ((rdata & m) === e) break;
    end
    if (i == n) begin
      fail($sformatf("reg %h read %h", a, rdata));
      if (n > 1) end_sim();
    end
  endtask : chk
  task automatic werr(input logic e);
    int i;
    tests_run++;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      if (clk_err === e) break;
    end
    if (i == 400) begin
      fail("clock error level");
      end_sim();
    end
  endtask : werr
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    foreach (ra[k]) chk(ra[k], rv[k], 8'hFF, 1);
    chk(8'h39, 8'h08, 8'h08, 200);
    werr(1'b1);
    wr(8'h30, 8'hFF);
    chk(8'h30, 8'h00, 8'hFF, 1);
    wr(8'h31, 8'h20);
    chk(8'h31, 8'h20, 8'h20, 1);
    wr(8'h31, 8'h00);
    run <= 1'b1;
    chk(8'h37, 8'h0B, 8'hFF, 3000);
    chk(8'h38, 8'h40, 8'hFF, 1);
    chk(8'h39, 8'h00, 8'h3F, 1000);
    werr(1'b0);
    // Every rate code; only auto and the supplied rate are clean
    foreach (rc[k]) begin
      wr(8'h28, {4'h0, rc[k]});
      chk(8'h39, {7'h00, !(rc[k] inside {4'h0, 4'hB})}, 8'h01, 20);
    end
    // Every ratio code; only the supplied ratio is clean
    foreach (qc[k]) begin
      wr(8'h28, {qc[k], 4'h0});
      chk(8'h39, (qc[k] == 4'h5) ? 8'h00 : 8'h02, 8'h02, 20);
    end
    wr(8'h28, 8'h39);
    werr(1'b1);
    wr(8'h29, 8'h18);
    werr(1'b0);
    chk(8'h39, 8'h03, 8'h03, 1);
    @(posedge clk);
    pll <= 1'b1;
    werr(1'b1);
    chk(8'h39, 8'h10, 8'h10, 20);
    wr(8'h29, 8'h58);
    werr(1'b0);
    @(posedge clk);
    pll <= 1'b0;
    wr(8'h28, 8'h00);
    wr(8'h29, 8'h00);
    // Slow bit clock: 200 system cycles per period
    half <= 16'h07D0;
    chk(8'h39, 8'h04, 8'h04, 500);
    werr(1'b1);
    @(posedge clk);
    half <= 16'h0050;
    run <= 1'b0;
    chk(8'h39, 8'h08, 8'h08, 500);
    // Data keeps moving with the clock stopped; nothing may be sampled
    tests_run++;
    s0 = samp;
    repeat (50) @(posedge clk);
    #1;
    if (samp !== s0) fail("sample without bit clock");
    werr(1'b1);
    wr(8'h29, 8'h3C);
    werr(1'b0);
    @(posedge clk);
    pll <= 1'b1;
    wr(8'h29, 8'h7C);
    // Give a leaking error time to reach the output
    repeat (20) @(posedge clk);
    werr(1'b0);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      pdat <= (k != 1);
      @(posedge clk);
      #1;
      tests_run++;
      if (sout !== (k != 1)) fail("serial out");
    end
    // Restart the link in inverted polarity; status must settle clean
    @(posedge clk);
    pll <= 1'b0;
    wr(8'h31, 8'h20);
    inv <= 1'b1;
    run <= 1'b1;
    chk(8'h39, 8'h00, 8'h3F, 1000);
    chk(8'h37, 8'h0B, 8'hFF, 1);
    chk(8'h38, 8'h40, 8'hFF, 1);
    // Reset in mid-run: polarity and ignore bits return to zero
    @(posedge clk);
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    chk(8'h29, 8'h00, 8'hFF, 1);
    chk(8'h31, 8'h00, 8'hFF, 1);
    werr(1'b1);
    end_sim();
  end
  // Backstop against a hang anywhere
  initial begin
    repeat (100000) @(posedge clk);
    fail("run limit");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
